// ==== rtl/sync_serial_port_pkg.sv ====
// constants and types of the synchronous serial audio port
// assumes a 32-bit register port with byte offsets and a free-running link clock
package sync_serial_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CLKDIV_OFFSET = 8'h04;
    localparam logic [7:0] TXDATA_OFFSET = 8'h08;
    localparam logic [7:0] RXDATA_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam int DIV_W = 8;
    localparam logic [7:0] CLKDIV_RESET = 8'h03;
    localparam int SLOT_W = 5;
    localparam logic [4:0] SLOTS_NORMAL_LAST = 5'h00;
    localparam logic [4:0] SLOTS_NET_MIN_LAST = 5'h01;
    localparam int TX_DIR = 0;
    localparam int RX_DIR = 1;
    localparam int DIRS = 2;

    // control register image, bit 0 is enable
    typedef struct packed {
        logic rx_frame_sync_invert;
        logic tx_frame_sync_invert;
        logic rx_clock_polarity;
        logic tx_clock_polarity;
        logic rx_word_length_sync;
        logic tx_word_length_sync;
        logic rx_fs_internal;
        logic rx_clk_internal;
        logic tx_fs_internal;
        logic tx_clk_internal;
        logic [SLOT_W-1:0] slots_minus1;
        logic network;
        logic gated;
        logic sync_mode;
        logic enable;
    } cfg_t;
    localparam cfg_t CTRL_RESET = '0;

    typedef struct packed {
        logic rx_overrun;
        logic rx_full;
        logic tx_empty;
    } status_t;
    localparam status_t STATUS_RESET = 3'h1;

    typedef enum {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum {RX_WAIT, RX_WORD} rx_state_t;
endpackage

// ==== rtl/sync_serial_port.sv ====
// synchronous serial audio port: register side on clock, serial side on link_clock
// assumes config is changed only while enable is low; pins resolved by the bench
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module sync_serial_port #(
    parameter int WORD_BITS = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clock,
    input wire logic [sync_serial_port_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sync_serial_port_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [sync_serial_port_pkg::DATA_W-1:0] reg_rdata,
    input wire logic tx_bit_clock_in,
    output logic tx_bit_clock_out,
    output logic tx_bit_clock_oe,
    input wire logic tx_frame_sync_in,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe,
    output logic tx_serial_data_out,
    output logic tx_serial_data_oe,
    input wire logic rx_bit_clock_in,
    output logic rx_bit_clock_out,
    output logic rx_bit_clock_oe,
    input wire logic rx_frame_sync_in,
    output logic rx_frame_sync_out,
    output logic rx_frame_sync_oe,
    input wire logic rx_serial_data_in
);
    import sync_serial_port_pkg::*;

    localparam int BIT_W = $clog2(WORD_BITS);
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_BITS - 1);
    localparam int CFG_W = $bits(cfg_t) + DIV_W;

    // second and third stage agree: the change counts
    function automatic logic agree(input logic [2:0] s);
        return s[1] == s[2];
    endfunction

    // ---------------- register side ----------------
    cfg_t ctrl;
    logic [DIV_W-1:0] clkdiv;
    logic [WORD_BITS-1:0] tx_word;
    logic [WORD_BITS-1:0] rx_data;
    status_t status;
    logic tx_empty;
    logic rx_full;
    logic rx_overrun;
    logic tx_req;
    logic [2:0] ack_s;
    logic ack_seen;
    logic [2:0] rxt_s;
    logic rxt_seen;
    logic tx_ack;
    logic rx_tgl;
    logic [WORD_BITS-1:0] rx_word;
    logic ack_event;
    logic rx_event;
    logic rx_clear;

    assign ack_event = agree(ack_s) && (ack_s[2] != ack_seen);
    assign rx_event = agree(rxt_s) && (rxt_s[2] != rxt_seen);
    assign rx_clear = reg_read && (reg_addr == RXDATA_OFFSET);
    assign status = {rx_overrun, rx_full, tx_empty};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            clkdiv <= CLKDIV_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                CTRL_OFFSET: ctrl <= cfg_t'(reg_wdata[$bits(cfg_t)-1:0]);
                CLKDIV_OFFSET: clkdiv <= reg_wdata[DIV_W-1:0];
                default: ;
            endcase
        end
    end

    // crossings from the link side
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_s <= '0;
            ack_seen <= 1'b0;
            rxt_s <= '0;
            rxt_seen <= 1'b0;
        end else begin
            ack_s <= {ack_s[1:0], tx_ack};
            rxt_s <= {rxt_s[1:0], rx_tgl};
            if (ack_event)
                ack_seen <= ack_s[2];
            if (rx_event)
                rxt_seen <= rxt_s[2];
        end
    end

    // tx word hand-over; a write while a word is pending is ignored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_word <= '0;
            tx_req <= 1'b0;
            tx_empty <= STATUS_RESET.tx_empty;
        end else if (reg_write && reg_addr == TXDATA_OFFSET && tx_empty) begin
            tx_word <= reg_wdata[WORD_BITS-1:0];
            tx_req <= ~tx_req;
            tx_empty <= 1'b0;
        end else if (ack_event) begin
            tx_empty <= 1'b1;
        end
    end

    // rx word; a new word beats a read clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_data <= '0;
            rx_full <= STATUS_RESET.rx_full;
            rx_overrun <= STATUS_RESET.rx_overrun;
        end else begin
            if (rx_event) begin
                rx_data <= rx_word;
                rx_full <= 1'b1;
            end else if (rx_clear) begin
                rx_full <= 1'b0;
            end
            if (rx_event && rx_full)
                rx_overrun <= 1'b1;
            else if (rx_clear)
                rx_overrun <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                CTRL_OFFSET: reg_rdata <= DATA_W'(ctrl);
                CLKDIV_OFFSET: reg_rdata <= DATA_W'(clkdiv);
                TXDATA_OFFSET: reg_rdata <= DATA_W'(tx_word);
                RXDATA_OFFSET: reg_rdata <= DATA_W'(rx_data);
                STATUS_OFFSET: reg_rdata <= DATA_W'(status);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ---------------- link side ----------------
    logic [2:0] lrst_s;
    logic link_rst_n;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [CFG_W-1:0] cfg_s3;
    cfg_t lcfg;
    logic [DIV_W-1:0] ldiv;
    logic [2:0] req_s;
    logic req_seen;
    logic req_event;
    logic en;
    logic gated;
    logic [SLOT_W-1:0] slots_last;
    logic [DIRS-1:0] clk_int;
    logic [DIRS-1:0] fs_int_sel;
    logic [DIRS-1:0] fs_wl;
    logic [DIRS-1:0] clk_pin;
    logic [DIRS-1:0] fs_pin;
    logic [2:0] clk_s [DIRS];
    logic [2:0] fs_s [DIRS];
    logic [2:0] rxd_s;
    logic [DIRS-1:0] clk_lv;
    logic [DIRS-1:0] fs_lv;
    logic [DIV_W-1:0] gen_cnt [DIRS];
    logic [DIRS-1:0] gen_clk;
    logic [DIRS-1:0] rise;
    logic [DIRS-1:0] fall;
    logic [DIRS-1:0] fs_line;
    logic [DIRS-1:0] fs_prev;
    logic [DIRS-1:0] fs_pending;
    logic [DIRS-1:0] fs_int;
    logic [DIRS-1:0] fr_busy;
    logic [BIT_W-1:0] fr_bit [DIRS];
    logic [SLOT_W-1:0] fr_slot [DIRS];
    logic [DIRS-1:0] frame_last;
    logic [DIRS-1:0] begin_frame;
    logic [DIRS-1:0] next_busy;
    logic [BIT_W-1:0] next_bit [DIRS];
    logic [SLOT_W-1:0] next_slot [DIRS];
    logic run;
    logic start_ok;
    logic tx_pending;
    logic [WORD_BITS-1:0] tx_hold;
    logic [WORD_BITS-1:0] tx_shift;
    tx_state_t tx_state;
    rx_state_t rx_state;
    logic [WORD_BITS-1:0] rx_shift;
    logic [BIT_W-1:0] rx_bit;
    logic [SLOT_W-1:0] rx_slot;
    logic rx_fs;
    logic rx_fs_prev;
    logic rx_fall;
    logic rx_start;
    logic [WORD_BITS-1:0] rx_next;

    assign link_rst_n = lrst_s[2];
    assign req_event = agree(req_s) && (req_s[2] != req_seen);
    assign en = lcfg.enable;
    assign gated = lcfg.gated && !lcfg.network;
    assign clk_int = {lcfg.rx_clk_internal, lcfg.tx_clk_internal};
    assign fs_int_sel = {lcfg.rx_fs_internal, lcfg.tx_fs_internal};
    assign fs_wl = {lcfg.rx_word_length_sync, lcfg.tx_word_length_sync};
    // input pins seen with their polarity removed
    assign clk_pin[TX_DIR] = tx_bit_clock_in ^ lcfg.tx_clock_polarity;
    assign clk_pin[RX_DIR] = rx_bit_clock_in ^ lcfg.rx_clock_polarity;
    assign fs_pin[TX_DIR] = tx_frame_sync_in ^ lcfg.tx_frame_sync_invert;
    assign fs_pin[RX_DIR] = rx_frame_sync_in ^ lcfg.rx_frame_sync_invert;

    always_comb begin
        if (!lcfg.network)
            slots_last = SLOTS_NORMAL_LAST;
        else if (lcfg.slots_minus1 < SLOTS_NET_MIN_LAST)
            slots_last = SLOTS_NET_MIN_LAST;
        else
            slots_last = lcfg.slots_minus1;
    end

    // clock keeps running unless gated and no word is under way
    assign run = en && (!gated || tx_pending
        || (tx_state == TX_SEND && fr_bit[TX_DIR] != BIT_LAST));
    assign start_ok = !gated || tx_pending;

    always_ff @(posedge link_clock) begin
        lrst_s <= {lrst_s[1:0], rst_n};
        cfg_s1 <= {ctrl, clkdiv};
        cfg_s2 <= cfg_s1;
        cfg_s3 <= cfg_s2;
        req_s <= {req_s[1:0], tx_req};
        rxd_s <= {rxd_s[1:0], rx_serial_data_in};
        for (int d = 0; d < DIRS; d++) begin
            clk_s[d] <= {clk_s[d][1:0], clk_pin[d]};
            fs_s[d] <= {fs_s[d][1:0], fs_pin[d]};
        end
    end

    always_ff @(posedge link_clock) begin
        if (!link_rst_n) begin
            lcfg <= CTRL_RESET;
            ldiv <= CLKDIV_RESET;
            clk_lv <= '0;
            fs_lv <= '0;
        end else begin
            if (cfg_s2 == cfg_s3)
                {lcfg, ldiv} <= cfg_s3;
            for (int d = 0; d < DIRS; d++) begin
                if (agree(clk_s[d]))
                    clk_lv[d] <= clk_s[d][2];
                if (agree(fs_s[d]))
                    fs_lv[d] <= fs_s[d][2];
            end
        end
    end

    // bit clock generators and edge events
    always_ff @(posedge link_clock) begin
        if (!link_rst_n) begin
            gen_clk <= '0;
            for (int d = 0; d < DIRS; d++)
                gen_cnt[d] <= '0;
        end else begin
            for (int d = 0; d < DIRS; d++) begin
                if (!en) begin
                    gen_cnt[d] <= '0;
                    gen_clk[d] <= 1'b0;
                end else if (gen_cnt[d] == ldiv) begin
                    gen_cnt[d] <= '0;
                    if (run || gen_clk[d])
                        gen_clk[d] <= ~gen_clk[d];
                end else begin
                    gen_cnt[d] <= gen_cnt[d] + DIV_W'(1);
                end
            end
        end
    end

    always_comb begin
        for (int d = 0; d < DIRS; d++) begin
            if (clk_int[d]) begin
                rise[d] = en && gen_cnt[d] == ldiv && !gen_clk[d] && run;
                fall[d] = en && gen_cnt[d] == ldiv && gen_clk[d];
            end else begin
                rise[d] = en && agree(clk_s[d]) && clk_s[d][2] && !clk_lv[d];
                fall[d] = en && agree(clk_s[d]) && !clk_s[d][2] && clk_lv[d];
            end
            fs_line[d] = fs_int_sel[d] ? fs_int[d] : fs_lv[d];
        end
    end

    // frame and slot counting per direction, applied on that direction's rise
    always_comb begin
        for (int d = 0; d < DIRS; d++) begin
            frame_last[d] = fr_busy[d] && fr_bit[d] == BIT_LAST && fr_slot[d] == slots_last;
            begin_frame[d] = fs_int_sel[d] ? ((!fr_busy[d] || frame_last[d]) && start_ok)
                : fs_pending[d];
            next_busy[d] = fr_busy[d];
            next_bit[d] = fr_bit[d];
            next_slot[d] = fr_slot[d];
            if (begin_frame[d]) begin
                next_busy[d] = 1'b1;
                next_bit[d] = '0;
                next_slot[d] = '0;
            end else if (frame_last[d]) begin
                next_busy[d] = 1'b0;
                next_bit[d] = '0;
                next_slot[d] = '0;
            end else if (fr_busy[d]) begin
                if (fr_bit[d] == BIT_LAST) begin
                    next_bit[d] = '0;
                    next_slot[d] = fr_slot[d] + SLOT_W'(1);
                end else begin
                    next_bit[d] = fr_bit[d] + BIT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge link_clock) begin
        if (!link_rst_n || !en) begin
            fr_busy <= '0;
            fs_int <= '0;
            fs_prev <= '0;
            fs_pending <= '0;
            for (int d = 0; d < DIRS; d++) begin
                fr_bit[d] <= '0;
                fr_slot[d] <= '0;
            end
        end else begin
            for (int d = 0; d < DIRS; d++) begin
                if (rise[d]) begin
                    fr_busy[d] <= next_busy[d];
                    fr_bit[d] <= next_bit[d];
                    fr_slot[d] <= next_slot[d];
                    fs_pending[d] <= 1'b0;
                    // sync high for bit 0 only, or for the whole first slot
                    fs_int[d] <= next_busy[d] && next_slot[d] == '0
                        && (fs_wl[d] || next_bit[d] == '0);
                end else if (fall[d]) begin
                    fs_prev[d] <= fs_line[d];
                    if (!fs_int_sel[d] && fs_line[d] && (!fs_prev[d] || !fr_busy[d]))
                        fs_pending[d] <= 1'b1;
                    if (gated && fr_bit[d] == BIT_LAST)
                        fr_busy[d] <= 1'b0;
                end
            end
        end
    end

    // transmit word path
    always_ff @(posedge link_clock) begin
        if (!link_rst_n) begin
            req_seen <= 1'b0;
            tx_pending <= 1'b0;
            tx_hold <= '0;
            tx_shift <= '0;
            tx_ack <= 1'b0;
            tx_state <= TX_IDLE;
        end else begin
            if (req_event) begin
                req_seen <= req_s[2];
                tx_pending <= 1'b1;
                tx_hold <= tx_word;
            end
            if (!en) begin
                tx_state <= TX_IDLE;
            end else if (rise[TX_DIR]) begin
                if (next_busy[TX_DIR] && next_bit[TX_DIR] == '0) begin
                    if (tx_pending && !req_event) begin
                        tx_shift <= tx_hold;
                        tx_pending <= 1'b0;
                        tx_ack <= ~tx_ack;
                        tx_state <= TX_SEND;
                    end else begin
                        tx_state <= TX_IDLE;
                    end
                end else if (tx_state == TX_SEND) begin
                    if (!next_busy[TX_DIR])
                        tx_state <= TX_IDLE;
                    else
                        tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
                end
            end else if (fall[TX_DIR] && gated && tx_state == TX_SEND
                && fr_bit[TX_DIR] == BIT_LAST) begin
                tx_state <= TX_IDLE;
            end
        end
    end

    // receive path: shared tx timing when synchronous, own timing otherwise
    always_comb begin
        if (lcfg.sync_mode) begin
            rx_fall = fall[TX_DIR];
            rx_fs = fs_line[TX_DIR];
        end else begin
            rx_fall = fall[RX_DIR];
            rx_fs = fs_line[RX_DIR];
        end
        rx_start = rx_fs && (!rx_fs_prev || rx_state == RX_WAIT);
        rx_next = {rx_shift[WORD_BITS-2:0], rxd_s[2]};
    end

    always_ff @(posedge link_clock) begin
        if (!link_rst_n) begin
            rx_state <= RX_WAIT;
            rx_shift <= '0;
            rx_bit <= '0;
            rx_slot <= '0;
            rx_fs_prev <= 1'b0;
            rx_word <= '0;
            rx_tgl <= 1'b0;
        end else if (!en) begin
            rx_state <= RX_WAIT;
            rx_fs_prev <= 1'b0;
        end else if (rx_fall) begin
            rx_fs_prev <= rx_fs;
            if (rx_start) begin
                rx_shift <= rx_next;
                rx_bit <= BIT_W'(1);
                rx_slot <= '0;
                rx_state <= RX_WORD;
            end else if (rx_state == RX_WORD) begin
                rx_shift <= rx_next;
                if (rx_bit == BIT_LAST) begin
                    rx_word <= rx_next;
                    rx_tgl <= ~rx_tgl;
                    rx_bit <= '0;
                    if (rx_slot == slots_last)
                        rx_state <= RX_WAIT;
                    else
                        rx_slot <= rx_slot + SLOT_W'(1);
                end else begin
                    rx_bit <= rx_bit + BIT_W'(1);
                end
            end
        end
    end

    // pin output stage, polarity applied on the way out
    always_ff @(posedge link_clock) begin
        if (!link_rst_n) begin
            tx_bit_clock_out <= 1'b0;
            tx_bit_clock_oe <= 1'b0;
            tx_frame_sync_out <= 1'b0;
            tx_frame_sync_oe <= 1'b0;
            tx_serial_data_out <= 1'b0;
            tx_serial_data_oe <= 1'b0;
            rx_bit_clock_out <= 1'b0;
            rx_bit_clock_oe <= 1'b0;
            rx_frame_sync_out <= 1'b0;
            rx_frame_sync_oe <= 1'b0;
        end else begin
            tx_bit_clock_out <= gen_clk[TX_DIR] ^ lcfg.tx_clock_polarity;
            tx_bit_clock_oe <= en && clk_int[TX_DIR];
            tx_frame_sync_out <= fs_int[TX_DIR] ^ lcfg.tx_frame_sync_invert;
            tx_frame_sync_oe <= en && fs_int_sel[TX_DIR];
            tx_serial_data_out <= tx_shift[WORD_BITS-1];
            tx_serial_data_oe <= tx_state == TX_SEND;
            rx_bit_clock_out <= gen_clk[RX_DIR] ^ lcfg.rx_clock_polarity;
            rx_bit_clock_oe <= en && clk_int[RX_DIR] && !lcfg.sync_mode;
            rx_frame_sync_out <= fs_int[RX_DIR] ^ lcfg.rx_frame_sync_invert;
            rx_frame_sync_oe <= en && fs_int_sel[RX_DIR] && !lcfg.sync_mode;
        end
    end
endmodule

// ==== test/sync_serial_port_sva.sv ====
// checker: serial pin timing against a control image seen on the register port
// assumes control changes only while the port is disabled
`timescale 1ns/10ps
module sync_serial_port_sva import sync_serial_port_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clock,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic tx_bit_clock_out,
    input wire logic tx_bit_clock_oe,
    input wire logic tx_frame_sync_out,
    input wire logic tx_frame_sync_oe,
    input wire logic tx_serial_data_out,
    input wire logic tx_serial_data_oe,
    input wire logic rx_bit_clock_oe,
    input wire logic rx_frame_sync_oe
);
    cfg_t c;
    logic [7:0] div;
    logic [7:0] still;
    logic [15:0] hi;
    logic [3:0] on;
    logic tck_q;
    wire tck = tx_bit_clock_out ^ c.tx_clock_polarity;
    wire tfs = tx_frame_sync_out ^ c.tx_frame_sync_invert;
    wire own = on == 4'hf && c.tx_clk_internal && c.tx_fs_internal;
    wire cont = own && (!c.gated || c.network);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            c <= CTRL_RESET;
            div <= CLKDIV_RESET;
        end else if (reg_write && reg_addr == CTRL_OFFSET) begin
            c <= cfg_t'(reg_wdata[18:0]);
        end else if (reg_write && reg_addr == CLKDIV_OFFSET) begin
            div <= reg_wdata[7:0];
        end
    end
    // settle time after enable, cycles since tck moved, sync pulse length
    always_ff @(posedge link_clock) begin
        on <= !c.enable ? 4'h0 : (on == 4'hf ? on : on + 4'h1);
        tck_q <= tck;
        still <= (tck != tck_q || !tx_bit_clock_oe) ? 8'h00 : still + 8'h01;
        hi <= tfs ? hi + 16'h0001 : 16'h0000;
    end
    sequence s_sync_held;
        tfs ##1 tfs;
    endsequence
    a_data_on_rise: assert property (@(posedge link_clock) disable iff (!rst_n)
        own && tx_serial_data_oe && $past(tx_serial_data_oe) && $changed(tx_serial_data_out)
        |-> $rose(tck)) else $error("tx data moved off a rising clock");
    a_sync_on_rise: assert property (@(posedge link_clock) disable iff (!rst_n)
        own && $changed(tfs) |-> $rose(tck)) else $error("frame sync moved off a rising clock");
    a_release_on_rise: assert property (@(posedge link_clock) disable iff (!rst_n)
        cont && $fell(tx_serial_data_oe) |-> $rose(tck)) else $error("tx release off a rise");
    a_gated_idle: assert property (@(posedge link_clock) disable iff (!rst_n)
        own && c.gated && !c.network && !tx_serial_data_oe && !$past(tx_serial_data_oe)
        |-> $stable(tck)) else $error("gated clock moved while idle");
    a_clock_runs: assert property (@(posedge link_clock) disable iff (!rst_n)
        cont && tx_bit_clock_oe |-> still <= div) else $error("continuous clock stalled");
    a_bit_sync_len: assert property (@(posedge link_clock) disable iff (!rst_n)
        own && !c.tx_word_length_sync && $fell(tfs) |-> hi == {7'h0, div, 1'b0} + 16'h2)
        else $error("bit sync length wrong");
    a_word_sync_len: assert property (@(posedge link_clock) disable iff (!rst_n)
        cont && c.tx_word_length_sync && $fell(tfs) |-> hi == ({8'h0, div} + 16'h1) << 5)
        else $error("word sync length wrong");
    a_word_has_sync: assert property (@(posedge link_clock) disable iff (!rst_n)
        own && !c.network && $rose(tx_serial_data_oe) |-> s_sync_held)
        else $error("word sent without frame sync");
    a_rx_pins_quiet: assert property (@(posedge link_clock) disable iff (!rst_n)
        on == 4'hf && c.sync_mode |-> !rx_bit_clock_oe && !rx_frame_sync_oe)
        else $error("rx pins driven in synchronous mode");
    a_sync_driven: assert property (@(posedge link_clock) disable iff (!rst_n)
        on == 4'hf && c.tx_fs_internal |-> tx_frame_sync_oe)
        else $error("tx frame sync not driven");
endmodule
bind sync_serial_port sync_serial_port_sva i_sync_serial_port_sva (.clock(clock), .rst_n(rst_n),
    .link_clock(link_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe),
    .tx_frame_sync_out(tx_frame_sync_out), .tx_frame_sync_oe(tx_frame_sync_oe),
    .tx_serial_data_out(tx_serial_data_out),
    .tx_serial_data_oe(tx_serial_data_oe), .rx_bit_clock_oe(rx_bit_clock_oe),
    .rx_frame_sync_oe(rx_frame_sync_oe));

// ==== test/codec_echo.sv ====
// far-side codec: sends back each bit it received, one bit period later
// assumes the bench resolves the clock pin level
`timescale 1ns/10ps
module codec_echo (
    input wire logic bit_clock,
    input wire logic clock_invert,
    input wire logic data_in,
    input wire logic data_oe,
    output logic data_back
);
    logic cap = 1'b0;
    wire ck = bit_clock ^ clock_invert;
    initial data_back = 1'b0;
    // released line reads as a changing level
    always @(negedge ck) cap <= data_oe ? data_in : ~cap;
    always @(posedge ck) data_back <= cap;
endmodule

// ==== test/sync_serial_port_bench.sv ====
// bench: register-port runs of each mode, serial data looped through the codec model
// assumes the checker is bound by its own file
`timescale 1ns/10ps
module sync_serial_port_bench;
    import sync_serial_port_pkg::*;
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic cinv = 1'b0;
    logic tck_o, tck_oe, tfs_o, tfs_oe, txd, txd_oe, rxd;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    wire tck_pin = tck_oe ? tck_o : 1'b0;
    wire tfs_pin = tfs_oe ? tfs_o : 1'b0;
    localparam cfg_t RUNS [6] = '{
        19'h01e02, // sync, bit sync, rx pins asked
        19'h2a602, // word sync, inverted clock and sync
        19'h06600, // async, rx clock and sync from pins
        19'h00606, // gated
        19'h0260a, // network, two slots, word sync
        19'h007fe}; // network, 32 slots, gated asked
    sync_serial_port i_sync_serial_port (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
        .reg_rdata(rdata), .tx_bit_clock_in(tck_pin), .tx_bit_clock_out(tck_o),
        .tx_bit_clock_oe(tck_oe), .tx_frame_sync_in(tfs_pin), .tx_frame_sync_out(tfs_o),
        .tx_frame_sync_oe(tfs_oe), .tx_serial_data_out(txd), .tx_serial_data_oe(txd_oe),
        .rx_bit_clock_in(tck_pin), .rx_bit_clock_out(), .rx_bit_clock_oe(),
        .rx_frame_sync_in(tfs_pin), .rx_frame_sync_out(), .rx_frame_sync_oe(),
        .rx_serial_data_in(rxd));
    codec_echo i_codec_echo (.bit_clock(tck_pin), .clock_invert(cinv), .data_in(txd),
        .data_oe(txd_oe), .data_back(rxd));
    initial forever #5 clock = ~clock;
    initial begin
        #7;
        forever #15 link_clock = ~link_clock;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        @(posedge clock);
        d = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic poll(input int b);
        logic [31:0] s;
        for (int i = 0; i < 500; i++) begin
            rd(STATUS_OFFSET, s);
            if (s[b] === 1'b1) return;
        end
        chk(s, s | (32'h1 << b));
    endtask
    task automatic run(input cfg_t c, input logic [15:0] w);
        logic [31:0] d;
        cinv = c.tx_clock_polarity;
        wr(CTRL_OFFSET, {13'h0, c});
        repeat (30) @(posedge clock);
        wr(CTRL_OFFSET, {13'h0, c} | 32'h1);
        wr(TXDATA_OFFSET, {16'h0, w});
        poll(0);
        rd(RXDATA_OFFSET, d);
        poll(1);
        rd(RXDATA_OFFSET, d);
        chk({17'h0, d[14:0]}, {17'h0, w[15:1]});
        wr(CTRL_OFFSET, 32'h0);
        repeat (30) @(posedge clock);
    endtask
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            chk(32'h0, 32'h1);
            conclude();
        end
    end
    initial begin
        logic [31:0] d;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (20) @(posedge clock);
        wr(8'h14, 32'hffffffff);
        rd(CTRL_OFFSET, d);
        chk(d, 32'h0);
        rd(CLKDIV_OFFSET, d);
        chk(d, {24'h0, CLKDIV_RESET});
        rd(STATUS_OFFSET, d);
        chk(d, {29'h0, STATUS_RESET});
        rd(8'h14, d);
        chk(d, 32'h0);
        wr(CLKDIV_OFFSET, 32'h7);
        rd(CLKDIV_OFFSET, d);
        chk(d, 32'h7);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            run(RUNS[i], 16'h3c5a + 16'(i) * 16'h1357);
            $display("test mode %0d done", i);
        end
        conclude();
    end
endmodule
